// *** verilog/rtc_flag_control_periodic_timer.sv ***
/*
 Flag, control and fixed-cycle timer registers of a serial real time
 clock, reached over the three-wire serial port (chip enable, shift
 clock, data). Drives the open-drain active-low interrupt pin.
 Assumes all pin inputs are asynchronous to clock_i and that the shift
 clock is far slower than clock_i. The alarm event comes from logic on
 clock_i as a one-cycle strobe.
*/
module rtc_flag_control_periodic_timer
#(
   parameter int unsigned RELEASE_SLOW_CYCLES = tmr_pkg::RELEASE_SLOW_CYCLES
)
(
   input  wire logic       clock_i,        // 25 MHz system clock
   input  wire logic       resetn_i,       // synchronous reset, low active
   input  wire logic       clk_en_i,       // freezes all state while low
   input  wire logic       ce_i,           // serial chip enable pin
   input  wire logic       sclk_i,         // serial shift clock pin
   input  wire logic       dio_i,          // serial data pin, input side
   output logic            dio_o,          // serial data pin, output side
   output logic            dio_oe_n_o,     // low while driving data pin
   input  wire logic       osc_32k_i,      // 32.768 kHz oscillator
   input  wire logic       low_voltage_i,  // supply loss detector, high active
   input  wire logic       alarm_event_i,  // alarm match strobe
   output logic            irq_o,          // interrupt pin level when driven
   output logic            irq_oe_n_o,     // low while pulling irq low
   output logic            wada_o,         // alarm target select bit
   output logic [1:0]      fsel_o          // frequency output select bits
);
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic       sclk_prev;
   logic       osc_prev;
   logic       ce_s;
   logic       sclk_s;
   logic       dio_s;
   logic       osc_s;
   logic       lv_s;
   logic       sclk_rise;
   logic       sclk_fall;

   tmr_pkg::serial_state_e state;
   logic [2:0] bitcnt;
   logic [7:0] shreg;
   logic [7:0] rd_sh;
   logic [3:0] addr;
   logic       wr_pend;
   logic [3:0] rd_sel_addr;
   logic [7:0] rdata;
   logic       wr_stb;

   logic [7:0] preset_lo;
   logic [7:0] preset_hi;
   logic [7:0] ext;
   logic [7:0] ctl;
   logic       tf;
   logic       af;
   logic       low_voltage_flag;
   logic [7:0] flags_rd;
   logic [11:0] preset;
   logic [11:0] count;
   logic [1:0] tsel;
   logic       te;
   logic       timer_irq_enable;
   logic       alarm_irq_enable;
   logic       src_tick;
   logic       timer_event;

   logic       wr_lo;
   logic       wr_hi;
   logic       wr_ext;
   logic       wr_flags;
   logic       wr_ctl;
   logic       te_start;
   logic       te_stop;
   logic       tf_clear;
   logic       tie_drop;
   logic       next_tf;
   logic       next_af;
   logic       next_vlf;

   logic                         timer_hold;
   logic [tmr_pkg::RELEASE_W-1:0] rel_cnt;
   logic [tmr_pkg::RELEASE_W-1:0] rel_load;
   logic                         irq_req;

   source_tick_if ticks ();

   source_clock_divider u_divider
   (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .clk_en_i (clk_en_i),
      .ticks    (ticks.gen)
   );

   // pin synchronisers; only sync2 and later stages are looked at
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         sync1     <= '0;
         sync2     <= '0;
         sclk_prev <= 1'b0;
         osc_prev  <= 1'b0;
      end
      else if (clk_en_i)
      begin
         sync1     <= {low_voltage_i, osc_32k_i, dio_i, sclk_i, ce_i};
         sync2     <= sync1;
         sclk_prev <= sync2[1];
         osc_prev  <= sync2[3];
      end
   end

   assign ce_s      = sync2[0];
   assign sclk_s    = sync2[1];
   assign dio_s     = sync2[2];
   assign osc_s     = sync2[3];
   assign lv_s      = sync2[4];
   assign sclk_rise = sclk_s & ~sclk_prev;
   assign sclk_fall = ~sclk_s & sclk_prev;

   assign ticks.osc_tick = osc_s & ~osc_prev;
   assign ticks.stop     = ctl[tmr_pkg::CTL_STOP];

   // serial port: command byte gives direction and start address, data
   // bytes follow with the address stepping after each byte
   assign rd_sel_addr = (state == tmr_pkg::SER_CMD) ? {shreg[2:0], dio_s} : addr + 4'h1;
   // a write lands at the falling edge after its last bit
   assign wr_stb      = (state == tmr_pkg::SER_WRITE) & wr_pend & sclk_fall;  // [R22]

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         state      <= tmr_pkg::SER_IDLE;
         bitcnt     <= '0;
         shreg      <= '0;
         rd_sh      <= '0;
         addr       <= '0;
         wr_pend    <= 1'b0;
         dio_o      <= 1'b0;
         dio_oe_n_o <= 1'b1;
      end
      else if (clk_en_i)
      begin
         if (!ce_s)
         begin
            state      <= tmr_pkg::SER_IDLE;
            bitcnt     <= '0;
            wr_pend    <= 1'b0;
            dio_oe_n_o <= 1'b1;
         end
         else
         begin
            unique case (state)
               tmr_pkg::SER_IDLE:
                  state <= tmr_pkg::SER_CMD;
               tmr_pkg::SER_CMD:
                  if (sclk_rise)
                  begin
                     shreg  <= {shreg[6:0], dio_s};
                     bitcnt <= bitcnt + 3'h1;
                     if (bitcnt == 3'h7)
                     begin
                        addr  <= {shreg[2:0], dio_s};
                        rd_sh <= rdata;
                        if (shreg[6:3] == tmr_pkg::CMD_READ)
                           state <= tmr_pkg::SER_READ;
                        else if (shreg[6:3] == tmr_pkg::CMD_WRITE)
                           state <= tmr_pkg::SER_WRITE;
                        else
                           state <= tmr_pkg::SER_IDLE;
                     end
                  end
               tmr_pkg::SER_WRITE:
               begin
                  if (sclk_rise)
                  begin
                     shreg  <= {shreg[6:0], dio_s};
                     bitcnt <= bitcnt + 3'h1;
                     if (bitcnt == 3'h7)
                        wr_pend <= 1'b1;
                  end
                  if (wr_stb)
                  begin
                     wr_pend <= 1'b0;
                     addr    <= addr + 4'h1;
                  end
               end
               tmr_pkg::SER_READ:
                  if (sclk_fall)
                  begin
                     dio_oe_n_o <= 1'b0;
                     dio_o      <= rd_sh[7];
                     bitcnt     <= bitcnt + 3'h1;
                     if (bitcnt == 3'h7)
                     begin
                        rd_sh <= rdata;
                        addr  <= addr + 4'h1;
                     end
                     else
                        rd_sh <= {rd_sh[6:0], 1'b0};
                  end
            endcase
         end
      end
   end

   // read side: test bits are not stored and come back as zero
   assign flags_rd = (8'(tf) << tmr_pkg::FLG_TF) | (8'(af) << tmr_pkg::FLG_AF)
                   | (8'(low_voltage_flag) << tmr_pkg::FLG_VLF);  // [R1] [R24]
   assign rdata = (rd_sel_addr == tmr_pkg::ADDR_PRESET_LO) ? preset_lo :
                  (rd_sel_addr == tmr_pkg::ADDR_PRESET_HI) ? preset_hi :
                  (rd_sel_addr == tmr_pkg::ADDR_EXT)       ? ext :
                  (rd_sel_addr == tmr_pkg::ADDR_FLAGS)     ? flags_rd :
                  (rd_sel_addr == tmr_pkg::ADDR_CTRL)      ? ctl : 8'h00;

   assign wr_lo    = wr_stb & (addr == tmr_pkg::ADDR_PRESET_LO);
   assign wr_hi    = wr_stb & (addr == tmr_pkg::ADDR_PRESET_HI);
   assign wr_ext   = wr_stb & (addr == tmr_pkg::ADDR_EXT);
   assign wr_flags = wr_stb & (addr == tmr_pkg::ADDR_FLAGS);
   assign wr_ctl   = wr_stb & (addr == tmr_pkg::ADDR_CTRL);

   assign te       = ext[tmr_pkg::EXT_TE];
   assign tsel     = ext[tmr_pkg::EXT_TSEL_LO +: 2];
   assign timer_irq_enable      = ctl[tmr_pkg::CTL_TIE];
   assign alarm_irq_enable      = ctl[tmr_pkg::CTL_AIE];
   assign preset   = {preset_hi[3:0], preset_lo};  // [R19]
   assign te_start = wr_ext & shreg[tmr_pkg::EXT_TE] & ~te;
   assign te_stop  = wr_ext & ~shreg[tmr_pkg::EXT_TE];
   assign tf_clear = wr_flags & ~shreg[tmr_pkg::FLG_TF] & tf;
   assign tie_drop = wr_ctl & ~shreg[tmr_pkg::CTL_TIE] & timer_irq_enable;

   // upper nibble of the high preset register is plain storage
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         preset_lo <= tmr_pkg::PRESET_RESET;
         preset_hi <= tmr_pkg::PRESET_RESET;
         ext       <= tmr_pkg::EXT_RESET;
         ctl       <= tmr_pkg::CTL_RESET;
      end
      else if (clk_en_i)
      begin
         if (wr_lo)
            preset_lo <= shreg;
         if (wr_hi)
            preset_hi <= shreg;
         if (wr_ext)
            ext <= shreg & tmr_pkg::EXT_WR_MASK;  // [R1] [R24]
         if (wr_ctl)
            ctl <= shreg & tmr_pkg::CTL_WR_MASK;  // [R1] [R24]
      end
   end

   assign src_tick = (tsel == tmr_pkg::TSEL_4096) ? ticks.tick_4096 :
                     (tsel == tmr_pkg::TSEL_64)   ? ticks.tick_64 :
                     (tsel == tmr_pkg::TSEL_1)    ? ticks.tick_1 :
                                                    ticks.tick_min;  // [R20] [R11]
   assign timer_event = te & src_tick & (count == 12'h001);  // [R14]

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
         count <= '0;
      else if (clk_en_i)
      begin
         if (te_start)
            count <= preset;  // [R13]
         else if (te & src_tick)
         begin
            // a zero preset never raises an event, it just reloads
            if (count <= 12'h001)
               count <= preset;  // [R15]
            else
               count <= count - 12'h001;  // [R14]
         end
      end
   end

   // flags: an event in the same cycle as a clearing write wins
   assign next_tf  = timer_event | (tf & ~(wr_flags & ~shreg[tmr_pkg::FLG_TF]));  // [R2]
   assign next_af  = alarm_event_i | (af & ~(wr_flags & ~shreg[tmr_pkg::FLG_AF]));  // [R3]
   assign next_vlf = lv_s | (low_voltage_flag & ~(wr_flags & ~shreg[tmr_pkg::FLG_VLF]));  // [R4] [R5]

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         tf  <= 1'b0;
         af  <= 1'b0;
         low_voltage_flag <= tmr_pkg::VLF_RESET;
      end
      else if (clk_en_i)
      begin
         tf  <= next_tf;
         af  <= next_af;
         low_voltage_flag <= next_vlf;
      end
   end

   assign rel_load = (tsel == tmr_pkg::TSEL_4096)
                   ? tmr_pkg::RELEASE_W'(tmr_pkg::RELEASE_FAST_CYCLES - 1)
                   : tmr_pkg::RELEASE_W'(RELEASE_SLOW_CYCLES - 1);  // [R21]

   // timer pull on the pin, with its self-release countdown
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         timer_hold <= 1'b0;
         rel_cnt    <= '0;
      end
      else if (clk_en_i)
      begin
         if (timer_event & timer_irq_enable)
         begin
            timer_hold <= 1'b1;  // [R7]
            rel_cnt    <= rel_load;
         end
         else if (te_stop | tf_clear | tie_drop)
            timer_hold <= 1'b0;  // [R16] [R17] [R18]
         else if (timer_hold)
         begin
            if (rel_cnt == '0)
               timer_hold <= 1'b0;  // [R12]
            else
               rel_cnt <= rel_cnt - 1'b1;
         end
      end
   end

   assign irq_req = timer_hold | (af & alarm_irq_enable);  // [R8] [R23]
   assign irq_o   = 1'b0;

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         irq_oe_n_o <= 1'b1;
         wada_o     <= 1'b0;
         fsel_o     <= 2'h0;
      end
      else if (clk_en_i)
      begin
         irq_oe_n_o <= ~irq_req;
         wada_o     <= ext[tmr_pkg::EXT_WADA];
         fsel_o     <= ext[tmr_pkg::EXT_FSEL_LO +: 2];
      end
   end
endmodule

// *** verilog/tmr_pkg.sv ***
/*
 Constants shared by the periodic timer block: register offsets, field
 positions, write masks, reset values, serial command codes, prescaler
 widths and interrupt release times.
 Assumes a 25 MHz system clock and a 32.768 kHz oscillator pin.
*/
// Summary of operation
// R1: factory test bits read zero, writes dropped
// R2: countdown event sets timer flag until cleared
// R3: alarm event sets alarm flag, held
// R4: supply loss sets low-voltage flag, held
// R5: writing zero clears low-voltage flag; one ignored
// R6: host initialises registers while low-voltage flag set
// R7: timer irq enable gates timer events onto pin
// R8: alarm irq enable gates alarm flag onto pin
// R9: stop bit halts the divider chain; the 4096 Hz stage keeps running
// R10: host uses stop only for timekeeping
// R11: interval up to 4095 slowest-source periods
// R12: timer low on pin self-releases after interval
// R13: enabling timer loads preset, never leftover count
// R14: decrement per tick; 001h to 000h raises event
// R15: reload preset after event, keep counting
// R16: disabling timer stops it, releases pin
// R17: clearing timer flag releases pin at once
// R18: dropping timer irq enable releases pin
// R19: 12-bit preset split low byte, high nibble
// R20: two select bits choose four source rates
// R21: release 122 us fast, 7.813 ms otherwise
// R22: counting starts at falling edge ending write
// R23: pin low while any enabled source asserts
// R24: fixed-zero bits read zero, writes ignored
package tmr_pkg;
   localparam logic [3:0] ADDR_PRESET_LO = 4'hB;
   localparam logic [3:0] ADDR_PRESET_HI = 4'hC;
   localparam logic [3:0] ADDR_EXT       = 4'hD;
   localparam logic [3:0] ADDR_FLAGS     = 4'hE;
   localparam logic [3:0] ADDR_CTRL      = 4'hF;

   localparam int EXT_WADA    = 6;
   localparam int EXT_TE      = 4;
   localparam int EXT_FSEL_LO = 2;
   localparam int EXT_TSEL_LO = 0;
   localparam int FLG_TF      = 4;
   localparam int FLG_AF      = 3;
   localparam int FLG_VLF     = 1;
   localparam int CTL_TIE     = 4;
   localparam int CTL_AIE     = 3;
   localparam int CTL_STOP    = 1;

   localparam logic [7:0] EXT_WR_MASK  = 8'h5F;
   localparam logic [7:0] CTL_WR_MASK  = 8'h1A;
   localparam logic [7:0] EXT_RESET    = 8'h00;
   localparam logic [7:0] CTL_RESET    = 8'h00;
   localparam logic [7:0] PRESET_RESET = 8'h00;
   localparam logic       VLF_RESET    = 1'b1;

   localparam logic [3:0] CMD_WRITE = 4'h0;
   localparam logic [3:0] CMD_READ  = 4'h8;

   localparam logic [1:0] TSEL_4096 = 2'h0;
   localparam logic [1:0] TSEL_64   = 2'h1;
   localparam logic [1:0] TSEL_1    = 2'h2;
   localparam logic [1:0] TSEL_MIN  = 2'h3;

   localparam int         DIV_LO_W    = 3;
   localparam int         DIV_HI_W    = 12;
   localparam int         DIV_64_W    = 6;
   localparam logic [5:0] SEC_LAST    = 6'h3B;

   localparam int CLOCK_MHZ           = 25;
   localparam int RELEASE_FAST_NS     = 122000;
   localparam int RELEASE_SLOW_NS     = 7813000;
   localparam int RELEASE_FAST_CYCLES = RELEASE_FAST_NS * CLOCK_MHZ / 1000;
   localparam int RELEASE_SLOW_CYCLES = RELEASE_SLOW_NS * CLOCK_MHZ / 1000;
   localparam int RELEASE_W           = 18;

   typedef enum logic [1:0] {SER_IDLE, SER_CMD, SER_WRITE, SER_READ} serial_state_e;
endpackage

// *** verilog/source_tick_if.sv ***
/*
 Carrier between the timer block and its source clock divider.
 Assumes both ends run on clock_i and all strobes last one cycle.
*/
interface source_tick_if;
   logic osc_tick;
   logic stop;
   logic tick_4096;
   logic tick_64;
   logic tick_1;
   logic tick_min;

   modport gen
   (
      input  osc_tick,
      input  stop,
      output tick_4096,
      output tick_64,
      output tick_1,
      output tick_min
   );

   modport consumer
   (
      output osc_tick,
      output stop,
      input  tick_4096,
      input  tick_64,
      input  tick_1,
      input  tick_min
   );
endinterface

// *** verilog/source_clock_divider.sv ***
/*
 Divides the synchronised 32.768 kHz oscillator ticks into the four
 countdown source strobes.
 Assumes osc_tick is a one-cycle strobe per oscillator period.
*/
module source_clock_divider
(
   input  wire logic     clock_i,   // system clock
   input  wire logic     resetn_i,  // synchronous reset, low active
   input  wire logic     clk_en_i,  // freezes state while low
   source_tick_if.gen    ticks      // strobes to the timer
);
   logic [tmr_pkg::DIV_LO_W-1:0] div_lo;
   logic [tmr_pkg::DIV_HI_W-1:0] div_hi;
   logic [5:0]                   sec;
   logic                         lo_wrap;
   logic                         hi_step;

   // the 4096 Hz stage keeps running under stop; only the slower chain halts
   assign lo_wrap         = ticks.osc_tick & (&div_lo);
   assign hi_step         = lo_wrap & ~ticks.stop;  // [R9]
   assign ticks.tick_4096 = lo_wrap;  // [R20]
   assign ticks.tick_64   = hi_step & (&div_hi[tmr_pkg::DIV_64_W-1:0]);
   assign ticks.tick_1    = hi_step & (&div_hi);
   assign ticks.tick_min  = ticks.tick_1 & (sec == tmr_pkg::SEC_LAST);

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         div_lo <= '0;
         div_hi <= '0;
         sec    <= '0;
      end
      else if (clk_en_i)
      begin
         if (ticks.osc_tick)
            div_lo <= div_lo + 1'b1;
         if (hi_step)
            div_hi <= div_hi + 1'b1;
         if (ticks.tick_min)
            sec <= '0;
         else if (ticks.tick_1)
            sec <= sec + 6'h01;
      end
   end
endmodule

// *** verification/tmr_checker_properties.sv ***
/*
 Port-level checks of the timer block, bound to its top module.
 Assumes a host that holds each shift clock phase at least five clocks.
*/
module tmr_checker
#(
   parameter int unsigned RELEASE_SLOW_CYCLES = 20
)
(
   input wire logic       clock_i,       // clock
   input wire logic       resetn_i,      // reset, low active
   input wire logic       clk_en_i,      // clock enable
   input wire logic       ce_i,          // chip enable pin
   input wire logic       sclk_i,        // shift clock pin
   input wire logic       dio_i,         // data pin in
   input wire logic       dio_o,         // data pin out
   input wire logic       dio_oe_n_o,    // data drive, low active
   input wire logic       osc_32k_i,     // oscillator
   input wire logic       low_voltage_i, // supply loss
   input wire logic       alarm_event_i, // alarm strobe
   input wire logic       irq_o,         // irq level
   input wire logic       irq_oe_n_o,    // irq pull, low active
   input wire logic       wada_o,        // alarm target
   input wire logic [1:0] fsel_o         // frequency select
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);

   // an alarm left pending would hold the pin low longer; the bench never does
   logic [11:0] low_run;
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i || irq_oe_n_o)
         low_run <= 12'h000;
      else
         low_run <= low_run + 12'h001;
   end

   property p_irq_level; irq_o == 1'b0; endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq level not low");
   property p_reset_out;
      $rose(resetn_i) |-> irq_oe_n_o && dio_oe_n_o && !wada_o && fsel_o == 2'h0;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not idle");
   property p_cfg_stable; (!ce_i) [*6] |-> $stable({wada_o, fsel_o}) && dio_oe_n_o; endproperty
   a_cfg_stable: assert property (p_cfg_stable) else $error("setup moved idle");
   property p_dio_in_frame; $fell(dio_oe_n_o) |-> $past(ce_i, 3); endproperty
   a_dio_in_frame: assert property (p_dio_in_frame) else $error("drive outside frame");
   property p_dio_after_fall; $changed(dio_o) && !dio_oe_n_o |-> !$past(sclk_i, 2); endproperty
   a_dio_after_fall: assert property (p_dio_after_fall) else $error("data moved early");
   property p_oe_frame_end; $fell(ce_i) |-> ##[1:6] dio_oe_n_o; endproperty
   a_oe_frame_end: assert property (p_oe_frame_end) else $error("drive kept");
   property p_irq_low_bound; low_run < 12'd3060; endproperty
   a_irq_low_bound: assert property (p_irq_low_bound) else $error("irq low too long");
   property p_irq_rel_slow; $rose(irq_oe_n_o) |-> $past(low_run) > 12'd10; endproperty
   a_irq_rel_slow: assert property (p_irq_rel_slow) else $error("irq glitch");

   c_irq: cover property ($fell(irq_oe_n_o));
   c_read: cover property ($fell(dio_oe_n_o));
   c_wada: cover property ($changed(wada_o));
endmodule

bind rtc_flag_control_periodic_timer tmr_checker
#(
   .RELEASE_SLOW_CYCLES(RELEASE_SLOW_CYCLES)
)
tmr_checker_inst
(
   .clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i), .ce_i(ce_i),
   .sclk_i(sclk_i), .dio_i(dio_i), .dio_o(dio_o), .dio_oe_n_o(dio_oe_n_o),
   .osc_32k_i(osc_32k_i), .low_voltage_i(low_voltage_i),
   .alarm_event_i(alarm_event_i), .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o),
   .wada_o(wada_o), .fsel_o(fsel_o)
);

// *** verification/serial_host_model.sv ***
/*
 Host side of the three-wire register port.
 Assumes xfer is entered just after a rising edge of clock_i.
*/
module serial_host_model
(
   input  wire logic clock_i,    // bench clock
   input  wire logic dev_dio_i,  // data from the block
   input  wire logic dev_oe_n_i, // low while the block drives
   output logic      ce_o,       // chip enable
   output logic      sclk_o,     // shift clock
   output logic      line_o      // resolved data line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv_en;
   logic drv_bit;
   logic last_line;
   // a released line shows the inverse of its last level, never a stale value
   assign line_o = !dev_oe_n_i ? dev_dio_i : (drv_en ? drv_bit : ~last_line);
   initial
   begin
      ce_o = 1'b0;
      sclk_o = 1'b0;
      drv_en = 1'b1;
      drv_bit = 1'b0;
      last_line = 1'b0;
   end
   always @(posedge clock_i)
   begin
      last_line <= line_o;
   end
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, wd};
      rd = 8'h00;
      ce_o <= 1'b1;
      repeat (5) @(posedge clock_i);
      for (int i = 15; i >= 0; i--)
      begin
         drv_en <= (i > 7) || !cmd[7];
         drv_bit <= sh[i];
         repeat (5) @(posedge clock_i);
         sclk_o <= 1'b1;
         if (i < 8)
            rd[i] = line_o;
         repeat (5) @(posedge clock_i);
         sclk_o <= 1'b0;
      end
      drv_en <= 1'b1;
      repeat (5) @(posedge clock_i);
      ce_o <= 1'b0;
      repeat (8) @(posedge clock_i);
   endtask
endmodule

// *** verification/rtc_flag_control_periodic_timer_tb.sv ***
/*
 Self-checking bench: a register model is compared with every read.
 Assumes a fast oscillator (16 clocks a period) to keep countdowns short.
*/
module rtc_flag_control_periodic_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock_i, resetn_i, osc, low_v, alarm_ev;
   logic       ce, sclk, line, dio_o, dio_oe_n_o, irq_o, irq_oe_n_o;
   logic [7:0] rv;
   logic       wada;
   logic [1:0] fsel;
   int         err_count, comparisons, cycles, seed, n, d1, p, d;
   int         regs_m[16];
   int         tf_m, af_m, vlf_m;
   int         addr_q[$] = '{7, 11, 12, 13, 15};

   rtc_flag_control_periodic_timer #(.RELEASE_SLOW_CYCLES(20)) rtc_flag_control_periodic_timer_inst
   (
      .clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(1'b1), .ce_i(ce), .sclk_i(sclk),
      .dio_i(line), .dio_o(dio_o), .dio_oe_n_o(dio_oe_n_o), .osc_32k_i(osc),
      .low_voltage_i(low_v), .alarm_event_i(alarm_ev), .irq_o(irq_o),
      .irq_oe_n_o(irq_oe_n_o), .wada_o(wada), .fsel_o(fsel)
   );
   serial_host_model serial_host_model_inst
   (
      .clock_i(clock_i), .dev_dio_i(dio_o), .dev_oe_n_i(dio_oe_n_o),
      .ce_o(ce), .sclk_o(sclk), .line_o(line)
   );

   function automatic int msk(input int a);
      case (a)
         11: return 'hFF;
         12: return 'h0F;
         13: return 'h5F;
         15: return 'h1A;
         default: return 0;
      endcase
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
         err_count++;
      end
   endtask
   task automatic wr(input int a, input int v);
      serial_host_model_inst.xfer({tmr_pkg::CMD_WRITE, a[3:0]}, v[7:0], rv);
      if (a == 14)
      begin
         tf_m = tf_m & v[4];
         af_m = af_m & v[3];
         vlf_m = vlf_m & v[1];
      end
      else
         regs_m[a] = v & msk(a);
   endtask
   task automatic rd(input int a);
      serial_host_model_inst.xfer({tmr_pkg::CMD_READ, a[3:0]}, 8'h00, rv);
      check("register", rv, (a == 14) ? tf_m * 16 + af_m * 8 + vlf_m * 2 : regs_m[a]);
   endtask
   task automatic wait_irq(input logic lvl, input int lim);
      n = 0;
      while (irq_oe_n_o !== lvl && n < lim)
      begin
         @(posedge clock_i);
         n++;
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end
   always @(posedge clock_i)
   begin
      cycles++;
      osc <= cycles[3];
      if (cycles == 90000)
      begin
         err_count++;
         tally_and_finish;
      end
   end

   initial
   begin
      seed = 48;
      resetn_i = 1'b0;
      osc = 1'b0;
      low_v = 1'b0;
      alarm_ev = 1'b0;
      vlf_m = 1;
      repeat (12) @(posedge clock_i);
      resetn_i <= 1'b1;
      @(posedge clock_i);
      foreach (addr_q[i]) rd(addr_q[i]);
      rd(14);
      wr(14, 'hFF); // ones into flags change nothing
      rd(14);
      wr(14, 0);
      rd(14);
      // host keeps factory bits and the run bit at zero here
      for (int k = 0; k < 4; k++)
         foreach (addr_q[i])
         begin
            d = $random(seed);
            d = (addr_q[i] == 13) ? ((d & 'h4C) | k) : (addr_q[i] == 7) ? d : (d & msk(addr_q[i]));
            wr(addr_q[i], d);
            rd(addr_q[i]);
            if (addr_q[i] == 13)
               check("setup pins", {wada, fsel}, {regs_m[13][6], regs_m[13][3:2]});
         end
      wr(15, 0);
      low_v <= 1'b1;
      repeat (4) @(posedge clock_i);
      low_v <= 1'b0;
      vlf_m = 1;
      rd(14);
      alarm_ev <= 1'b1;
      @(posedge clock_i);
      alarm_ev <= 1'b0;
      af_m = 1;
      repeat (5) @(posedge clock_i);
      check("irq masked alarm", irq_oe_n_o, 1);
      rd(14);
      wr(15, 'h08);
      check("irq alarm", irq_oe_n_o, 0);
      wr(14, 0);
      check("irq alarm cleared", irq_oe_n_o, 1);
      p = 25 + ($unsigned($random(seed)) % 6);
      wr(11, p);
      wr(12, 0);
      wr(15, 'h10);
      wr(13, 'h10);
      wait_irq(0, p * 128 + 400);
      check("first event", n + 20 >= (p - 1) * 128 && n <= p * 128, 1);
      wait_irq(1, 4000);
      d1 = n;
      check("release fast", d1 >= 3049 && d1 <= 3052, 1);
      wait_irq(0, 5000);
      check("interval", d1 + n, p * 128);
      tf_m = 1;
      rd(14);
      wr(14, 0);
      check("flag clear release", irq_oe_n_o, 1);
      wait_irq(0, 5000);
      wr(15, 0);
      check("enable drop release", irq_oe_n_o, 1);
      wait_irq(0, p * 128 + 200);
      check("event without enable", irq_oe_n_o, 1);
      tf_m = 1;
      rd(14);
      wr(15, 'h10);
      wait_irq(0, p * 128 + 200);
      wr(13, 0);
      check("stop release", irq_oe_n_o, 1);
      wait_irq(0, p * 128 + 200);
      check("stopped timer", irq_oe_n_o, 1);
      wr(11, 1);
      wr(13, 'h11);
      wait_irq(0, 8800);
      check("slow event", irq_oe_n_o, 0);
      wait_irq(1, 100);
      check("release slow", n >= 19 && n <= 23, 1);
      wr(15, 'h12);
      wait_irq(0, 9000);
      check("halted", irq_oe_n_o, 1);
      wr(15, 'h10);
      wait_irq(0, 8800);
      check("resumed", irq_oe_n_o, 0);
      wr(13, 0);
      tally_and_finish;
   end
endmodule
